// >>> rtl/csip_pkg.sv
// constants, register map and state types for the channel serial input port
package csip_pkg;

  // register indices; byte address is four times the index
  localparam logic [5:0] IDX_MODE = 6'h0c;
  localparam logic [5:0] IDX_DIV = 6'h0d;
  localparam logic [5:0] IDX_CTRL = 6'h16;
  localparam logic [5:0] IDX_CHAN_STATE = 6'h04;
  localparam logic [5:0] IDX_INTERP_NUM = 6'h30;
  localparam logic [5:0] IDX_INTERP_DEN = 6'h31;
  localparam logic [5:0] IDX_LATENCY = 6'h32;
  localparam logic [5:0] IDX_HOLDOFF = 6'h33;
  localparam logic [5:0] IDX_RX_DATA = 6'h34;
  localparam logic [5:0] IDX_STATUS = 6'h35;

  // field positions
  localparam int MODE_LSB = 4;
  localparam int WIDE_BIT = 9;
  localparam int DIV_LSB = 0;
  localparam int DIV_W = 5;
  localparam int EXT_BIT = 7;
  localparam int ADJ_BIT = 6;
  localparam int FES_BIT = 5;
  localparam int SLAVE_BIT = 4;
  localparam int SLEEP_BIT = 0;
  localparam int CRST_BIT = 1;
  localparam int LEGACY_BIT = 2;
  localparam int ST_MODE_LSB = 0;
  localparam int ST_CNT_LSB = 4;
  localparam int ST_LAT_BIT = 10;
  localparam int ST_BUSY_BIT = 11;
  localparam int CTL_M_BIT = 7;
  localparam int CTL_S_BIT = 6;

  // serial word formats
  localparam logic [2:0] FMT_FIR = 3'h0;
  localparam logic [2:0] FMT_DQPSK = 3'h1;
  localparam logic [2:0] FMT_GMSK = 3'h2;
  localparam logic [2:0] FMT_MSK = 3'h3;
  localparam logic [2:0] FMT_COMPACT = 3'h4;
  localparam logic [2:0] FMT_PSK8 = 3'h5;
  localparam logic [2:0] FMT_PSK8R = 3'h6;
  localparam logic [2:0] FMT_QPSK = 3'h7;

  typedef struct packed {
    logic [2:0] mode;
    logic wide24;
    logic [4:0] div;
    logic ext_frame;
    logic adj_frame;
    logic frame_end_sel;
    logic clock_slave;
    logic sleep;
    logic chan_rst;
    logic legacy;
    logic [15:0] interp_num;
    logic [7:0] interp_den;
    logic [15:0] latency;
    logic [15:0] holdoff;
  } csip_regs_t;

  localparam csip_regs_t REGS_RST = '{mode: 3'h0, wide24: 1'b0, div: 5'h00,
    ext_frame: 1'b0, adj_frame: 1'b0, frame_end_sel: 1'b0, clock_slave: 1'b0,
    sleep: 1'b1, chan_rst: 1'b0, legacy: 1'b0, interp_num: 16'h0100,
    interp_den: 8'h01, latency: 16'h0010, holdoff: 16'h0000};

  // completed word handed downstream
  typedef struct packed {
    logic valid;
    logic [5:0] len;
    logic [31:0] data;
    logic [15:0] i;
    logic [15:0] q;
  } csip_word_t;

endpackage

// >>> rtl/csip_port.sv
// channel serial input port with AHB-Lite register slave
`timescale 1ns/1ps

// Function
// - serial clock driven when clock-slave bit is 0, input when 1.
// - master clock held low in sleep, starts first edge after wake.
// - master clock divides by divider+1, or twice that in legacy mode.
// - divider is 5-bit field, bits 4..0 of register 0D.
// - master mode: frame out changes and data sampled on rising clock.
// - slave mode: host clocks, data sampled on falling clock edge.
// - bit 7 picks self or external framing; bit 6 pin or neighbour.
// - self framing ignores frame pin, pulses frame out one bit clock.
// - frame rate is bus clock hclk over channel interpolation factor.
// - non-integer ratio stretches some frames by up to one bit clock; average rate stays num/den.
// - frame out low in sleep; first frame delayed after channel reset.
// - frame out is request when bit 5 is 0, frame end when 1.
// - neighbour framing uses previous channel's internal frame end.
// - external framing: rising edges as master, falling edges as slave.
// - 3-bit mode field selects word format and length.
// - 32-bit word is 16-bit I then 16-bit Q, MSB first.
// - first bit taken on the bit clock edge after the frame pulse.
// - surplus bit clock edges before next frame are ignored.
// - frame lengths from one bit up to 32 bits.
// - stream mode bit sets format MSB when hold-off counter reaches one.
module csip_port (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic sclk_in,
  output logic sclk_out,
  output logic sclk_oe,
  input wire logic frame_sync_in,
  input wire logic serial_payload_in,
  input wire logic prev_frame_end,
  output logic frame_sync_out,
  output logic frame_end_out,
  output csip_pkg::csip_word_t rx_word
);

  typedef struct packed {
    csip_pkg::csip_regs_t regs;
    logic [31:0] hrdata;
    logic wr_pend;
    logic [5:0] wr_idx;
    logic [6:0] sclk_cnt;
    logic sclk_q;
    logic sclk_oe;
    logic sclk_prev;
    logic [16:0] acc;
    logic frame_pend;
    logic [15:0] lat_cnt;
    logic frame_out;
    logic frame_end;
    logic armed;
    logic busy;
    logic [5:0] bit_cnt;
    logic [31:0] shreg;
    csip_pkg::csip_word_t word;
    logic [31:0] last_data;
    logic [15:0] hold_cnt;
    logic pend_m;
  } csip_state_t;

  csip_state_t st;
  csip_state_t next_st;

  // bits per frame for each format
  function automatic logic [5:0] csip_len(input logic [2:0] fmt, input logic wide);
    logic [5:0] n;
    n = 6'd32;
    unique case (fmt)
      csip_pkg::FMT_FIR: n = 6'd32;
      csip_pkg::FMT_DQPSK: n = 6'd2;
      csip_pkg::FMT_GMSK: n = 6'd1;
      csip_pkg::FMT_MSK: n = 6'd1;
      csip_pkg::FMT_COMPACT: n = wide ? 6'd24 : 6'd16;
      csip_pkg::FMT_PSK8: n = 6'd3;
      csip_pkg::FMT_PSK8R: n = 6'd3;
      csip_pkg::FMT_QPSK: n = 6'd2;
    endcase
    return n;
  endfunction

  logic addr_phase;
  logic [31:0] rd;
  logic [6:0] period;
  logic [6:0] nx_cnt;
  logic master_on;
  logic master_evt;
  logic slave_evt;
  logic evt;
  logic seen;
  logic [5:0] len;
  logic [5:0] cnt_new;
  logic complete;
  logic [16:0] sum;
  logic chan_live;

  always_comb begin
    next_st = st;
    rd = 32'h0000_0000;
    period = 7'h00;
    nx_cnt = 7'h00;
    sum = 17'h00000;
    cnt_new = 6'h00;
    complete = 1'b0;
    next_st.word.valid = 1'b0;

    // bus side: write data lands one cycle after its address phase
    addr_phase = hsel & htrans[1] & hready;
    if (st.wr_pend) begin
      unique case (st.wr_idx)
        csip_pkg::IDX_MODE: begin
          next_st.regs.mode = hwdata[csip_pkg::MODE_LSB +: 3];
          next_st.regs.wide24 = hwdata[csip_pkg::WIDE_BIT];
        end
        csip_pkg::IDX_DIV: next_st.regs.div = hwdata[csip_pkg::DIV_LSB +: csip_pkg::DIV_W];
        csip_pkg::IDX_CTRL: begin
          next_st.regs.ext_frame = hwdata[csip_pkg::EXT_BIT];
          next_st.regs.adj_frame = hwdata[csip_pkg::ADJ_BIT];
          next_st.regs.frame_end_sel = hwdata[csip_pkg::FES_BIT];
          next_st.regs.clock_slave = hwdata[csip_pkg::SLAVE_BIT];
        end
        csip_pkg::IDX_CHAN_STATE: begin
          next_st.regs.sleep = hwdata[csip_pkg::SLEEP_BIT];
          next_st.regs.chan_rst = hwdata[csip_pkg::CRST_BIT];
          next_st.regs.legacy = hwdata[csip_pkg::LEGACY_BIT];
        end
        csip_pkg::IDX_INTERP_NUM: next_st.regs.interp_num = hwdata[15:0];
        csip_pkg::IDX_INTERP_DEN: next_st.regs.interp_den = hwdata[7:0];
        csip_pkg::IDX_LATENCY: next_st.regs.latency = hwdata[15:0];
        csip_pkg::IDX_HOLDOFF: next_st.regs.holdoff = hwdata[15:0];
        default: ;
      endcase
    end
    next_st.wr_pend = addr_phase & hwrite;
    next_st.wr_idx = haddr[7:2];

    // read data is registered during the address phase, so zero wait states
    unique case (haddr[7:2])
      csip_pkg::IDX_MODE: begin
        rd[csip_pkg::MODE_LSB +: 3] = st.regs.mode;
        rd[csip_pkg::WIDE_BIT] = st.regs.wide24;
      end
      csip_pkg::IDX_DIV: rd[csip_pkg::DIV_LSB +: csip_pkg::DIV_W] = st.regs.div;
      csip_pkg::IDX_CTRL: begin
        rd[csip_pkg::EXT_BIT] = st.regs.ext_frame;
        rd[csip_pkg::ADJ_BIT] = st.regs.adj_frame;
        rd[csip_pkg::FES_BIT] = st.regs.frame_end_sel;
        rd[csip_pkg::SLAVE_BIT] = st.regs.clock_slave;
      end
      csip_pkg::IDX_CHAN_STATE: begin
        rd[csip_pkg::SLEEP_BIT] = st.regs.sleep;
        rd[csip_pkg::CRST_BIT] = st.regs.chan_rst;
        rd[csip_pkg::LEGACY_BIT] = st.regs.legacy;
      end
      csip_pkg::IDX_INTERP_NUM: rd[15:0] = st.regs.interp_num;
      csip_pkg::IDX_INTERP_DEN: rd[7:0] = st.regs.interp_den;
      csip_pkg::IDX_LATENCY: rd[15:0] = st.regs.latency;
      csip_pkg::IDX_HOLDOFF: rd[15:0] = st.regs.holdoff;
      csip_pkg::IDX_RX_DATA: rd = st.last_data;
      csip_pkg::IDX_STATUS: begin
        rd[csip_pkg::ST_MODE_LSB +: 3] = st.regs.mode;
        rd[csip_pkg::ST_CNT_LSB +: 6] = st.bit_cnt;
        rd[csip_pkg::ST_LAT_BIT] = (st.lat_cnt != 16'h0000);
        rd[csip_pkg::ST_BUSY_BIT] = st.busy;
      end
      default: rd = 32'h0000_0000; // unmapped reads as zero
    endcase
    next_st.hrdata = (addr_phase & ~hwrite) ? rd : 32'h0000_0000;

    chan_live = ~st.regs.sleep & ~st.regs.chan_rst;

    // master bit clock; held at the last count so the first live edge rises
    next_st.sclk_oe = ~st.regs.clock_slave;
    period = st.regs.legacy ? {1'b0, st.regs.div, 1'b0} + 7'd2
                            : {2'b00, st.regs.div} + 7'd1;
    master_on = chan_live & ~st.regs.clock_slave;
    nx_cnt = (st.sclk_cnt >= period - 7'd1) ? 7'h00 : st.sclk_cnt + 7'd1;
    if (!master_on) begin
      next_st.sclk_cnt = period - 7'd1;
      next_st.sclk_q = 1'b0;
    end else begin
      next_st.sclk_cnt = nx_cnt;
      next_st.sclk_q = (nx_cnt < {1'b0, period[6:1]}) | (period == 7'd1);
    end
    master_evt = master_on & (nx_cnt == 7'h00);
    // slave clock arrives synchronous to hclk; falling edge is the bit edge
    next_st.sclk_prev = sclk_in;
    slave_evt = chan_live & st.regs.clock_slave & st.sclk_prev & ~sclk_in;
    evt = master_evt | slave_evt;

    // frame rate accumulator: num/den clocks per frame, rounded frame by frame
    if (st.regs.chan_rst) begin
      next_st.lat_cnt = st.regs.latency;
      next_st.acc = 17'h00000;
      next_st.frame_pend = 1'b0;
    end else if (st.lat_cnt != 16'h0000) begin
      next_st.lat_cnt = st.lat_cnt - 16'd1;
    end else if (!st.regs.sleep && st.regs.interp_den != 8'h00) begin
      if (evt && !st.regs.ext_frame) begin
        next_st.frame_pend = 1'b0;
      end
      sum = st.acc + {9'h000, st.regs.interp_den};
      if (sum >= {1'b0, st.regs.interp_num}) begin
        next_st.acc = sum - {1'b0, st.regs.interp_num};
        next_st.frame_pend = 1'b1;
      end else begin
        next_st.acc = sum;
      end
    end

    // frame source; self framing never looks at the frame pin
    if (!st.regs.ext_frame) begin
      seen = evt & st.frame_pend;
    end else if (st.regs.adj_frame) begin
      seen = evt & prev_frame_end;
    end else begin
      seen = evt & frame_sync_in;
    end

    // capture: a new frame restarts, a partial word is dropped
    len = csip_len(st.regs.mode, st.regs.wide24);
    if (evt) begin
      next_st.armed = seen;
      if (st.armed) begin
        // a new frame starts from a clean register so short words stay right-aligned
        next_st.shreg = {31'h0000_0000, serial_payload_in};
        cnt_new = 6'd1;
        next_st.busy = 1'b1;
      end else if (st.busy && st.bit_cnt < len) begin
        next_st.shreg = {st.shreg[30:0], serial_payload_in};
        cnt_new = st.bit_cnt + 6'd1;
      end else begin
        cnt_new = st.bit_cnt;
      end
      next_st.bit_cnt = cnt_new;
      complete = (st.armed | st.busy) & (cnt_new == len) & (cnt_new != st.bit_cnt | st.armed);
      if (complete) begin
        next_st.busy = 1'b0;
        next_st.word.valid = 1'b1;
        next_st.word.len = len;
        next_st.word.data = next_st.shreg;
        next_st.last_data = next_st.shreg;
        // 32-bit word: upper half is I, lower half is Q, both MSB first
        next_st.word.i = (len == 6'd32) ? next_st.shreg[31:16] : 16'h0000;
        next_st.word.q = (len == 6'd32) ? next_st.shreg[15:0] : 16'h0000;
      end
      // frame pins hold for one whole bit clock, changing only on bit edges
      next_st.frame_end = complete;
      next_st.frame_out = st.regs.frame_end_sel ? complete
                                                : (seen & ~st.regs.ext_frame);
    end

    // stream control bits ride in the low byte of a 24-bit compact word
    if (st.hold_cnt != 16'h0000) begin
      next_st.hold_cnt = st.hold_cnt - 16'd1;
      if (st.hold_cnt == 16'd1) begin
        next_st.regs.mode[2] = st.pend_m;
      end
    end
    if (complete && len == 6'd24 && next_st.shreg[csip_pkg::CTL_S_BIT]) begin
      next_st.hold_cnt = st.regs.holdoff;
      next_st.pend_m = next_st.shreg[csip_pkg::CTL_M_BIT];
    end

    // sleep and channel reset silence the frame pins and the capture
    if (!chan_live) begin
      next_st.frame_out = 1'b0;
      next_st.frame_end = 1'b0;
      next_st.armed = 1'b0;
      next_st.busy = 1'b0;
      next_st.bit_cnt = 6'h00;
    end
  end

  // single state register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st <= '0;
      st.regs <= csip_pkg::REGS_RST;
      st.sclk_oe <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign hrdata = st.hrdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign sclk_out = st.sclk_q;
  assign sclk_oe = st.sclk_oe;
  assign frame_sync_out = st.frame_out;
  assign frame_end_out = st.frame_end;
  assign rx_word = st.word;

endmodule // csip_port

// >>> verification/csip_port_properties.sv
// concurrent checks on the serial input port pins and bus answer
`timescale 1ns/1ps
module csip_port_properties (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic sclk_in,
  input wire logic sclk_out,
  input wire logic sclk_oe,
  input wire logic frame_sync_out,
  input wire csip_pkg::csip_word_t rx_word
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  // bit clock rises seen while a frame pulse stands; a second means a stretched pulse
  logic [1:0] fe_cnt;
  logic sclk_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fe_cnt <= 2'h0;
      sclk_q <= 1'b0;
    end else begin
      sclk_q <= sclk_out;
      if (!frame_sync_out) fe_cnt <= 2'h0;
      else if (sclk_out && !sclk_q && fe_cnt != 2'h3) fe_cnt <= fe_cnt + 2'h1;
    end
  end
  property p_rdata_idle;
    !(hsel && htrans[1] && hready && !hwrite) |=> hrdata == 32'h0;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside data phase");
  // one cycle of slack: the pin direction and the clock register settle together
  property p_slave_quiet;
    !sclk_oe && !$past(sclk_oe) |-> !sclk_out;
  endproperty
  a_slave_quiet: assert property (p_slave_quiet) else $error("clock driven in slave mode");
  property p_master_edges;
    sclk_oe && ($changed(frame_sync_out) || rx_word.valid) |-> $rose(sclk_out);
  endproperty
  a_master_edges: assert property (p_master_edges) else $error("master event off edge");
  property p_slave_fall;
    rx_word.valid && !sclk_oe |-> $past(sclk_in, 2) && !$past(sclk_in);
  endproperty
  a_slave_fall: assert property (p_slave_fall) else $error("slave word not on fall");
  property p_frame_one;
    fe_cnt <= 2'h1;
  endproperty
  a_frame_one: assert property (p_frame_one) else $error("frame pulse too long");
  property p_len_legal;
    rx_word.valid |-> rx_word.len inside {6'd32, 6'd24, 6'd16, 6'd3, 6'd2, 6'd1};
  endproperty
  a_len_legal: assert property (p_len_legal) else $error("illegal word length");
  property p_iq_split;
    rx_word.valid && rx_word.len == 6'd32 |-> {rx_word.i, rx_word.q} == rx_word.data;
  endproperty
  a_iq_split: assert property (p_iq_split) else $error("halves differ from word");
  property p_word_pulse;
    rx_word.valid |=> !rx_word.valid;
  endproperty
  a_word_pulse: assert property (p_word_pulse) else $error("word valid too long");
endmodule // csip_port_properties

bind csip_port csip_port_properties u_csip_port_properties (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hrdata(hrdata), .sclk_in(sclk_in), .sclk_out(sclk_out),
  .sclk_oe(sclk_oe), .frame_sync_out(frame_sync_out), .rx_word(rx_word)
);

// >>> verification/csip_host.sv
// behavioural host that clocks and frames payload words into the port
`timescale 1ns/1ps
module csip_host (
  input wire logic hclk,
  input wire logic sclk_out,
  input wire logic frame_sync_out,
  output logic sclk_in,
  output logic frame_sync_in,
  output logic serial_payload_in
);
  // clock stands low while no word is being sent
  initial begin
    sclk_in = 1'b0;
    frame_sync_in = 1'b0;
    serial_payload_in = 1'b0;
  end
  // one slave bit: the host owns the clock and the port samples at its fall
  task automatic sbit(input logic f, input logic d);
    repeat (2) @(posedge hclk);
    sclk_in <= 1'b1;
    frame_sync_in <= f;
    serial_payload_in <= d;
    repeat (2) @(posedge hclk);
    sclk_in <= 1'b0;
  endtask
  // surplus edges first, which the port must ignore until the frame
  task automatic send_slave(input logic [31:0] v, input int len);
    repeat (2) sbit(1'b0, ~serial_payload_in);
    sbit(1'b1, ~serial_payload_in);
    for (int b = len - 1; b >= 0; b--) sbit(1'b0, v[b]);
  endtask
  // master: each bit goes out just after the edge that took the one before
  task automatic send_master(input logic [31:0] v, input int len);
    logic p;
    int n;
    n = 0;
    serial_payload_in = ~serial_payload_in;
    do begin
      p = frame_sync_out;
      @(posedge hclk);
      #1;
      n++;
    end while (!(frame_sync_out && !p) && n < 4000);
    serial_payload_in = v[len - 1];
    for (int b = len - 2; b >= 0; b--) begin
      n = 0;
      do begin
        p = sclk_out;
        @(posedge hclk);
        #1;
        n++;
      end while (!(sclk_out && !p) && n < 100);
      serial_payload_in = v[b];
    end
  endtask
endmodule // csip_host

// >>> verification/csip_port_tb.sv
// self-checking bench for the channel serial input port
`timescale 1ns/1ps
module csip_port_tb;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, rd;
  logic hready, hreadyout, hresp, sclk_in, sclk_out, sclk_oe;
  logic frame_sync_in, serial_payload_in, frame_sync_out, frame_end_out;
  csip_pkg::csip_word_t rx_word, got;
  int bad_count = 0;
  int samples_checked = 0;
  int lens [9] = '{32, 2, 1, 1, 16, 3, 3, 2, 24};
  // one slave on the bus, so its ready is the bus ready
  assign hready = hreadyout;
  always #12.5 hclk = ~hclk;
  csip_port u_csip_port (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .sclk_in(sclk_in),
    .sclk_out(sclk_out), .sclk_oe(sclk_oe), .frame_sync_in(frame_sync_in),
    .serial_payload_in(serial_payload_in), .prev_frame_end(1'b0),
    .frame_sync_out(frame_sync_out), .frame_end_out(frame_end_out), .rx_word(rx_word));
  csip_host u_csip_host (.hclk(hclk), .sclk_out(sclk_out), .frame_sync_out(frame_sync_out),
    .sclk_in(sclk_in), .frame_sync_in(frame_sync_in), .serial_payload_in(serial_payload_in));
  task automatic end_sim;
    $display("checked %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic tmo;
    bad_count++;
    end_sim;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      bad_count++;
    end
  endtask
  // ready is looked at mid-cycle so the edge that samples it is never raced
  task automatic rdy;
    int n;
    n = 0;
    do begin
      @(negedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (n >= 50) tmo;
  endtask
  task automatic bus(input logic w, input logic [5:0] i, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, i, 2'b00};
    hwrite <= w;
    htrans <= 2'h2;
    rdy;
    @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    rdy;
    rd = hrdata;
    @(posedge hclk);
  endtask
  // period between two rises of the bit clock or of the frame pin
  task automatic per(input logic f, input int e);
    int n, c, t0;
    logic p, s;
    n = 0;
    c = 0;
    t0 = 0;
    p = 1'b1;
    while (c < 2) begin
      @(posedge hclk);
      #1;
      n++;
      if (n > 400) tmo;
      s = f ? frame_sync_out : sclk_out;
      if (s && !p) begin
        if (c > 0) chk(n - t0, e);
        t0 = n;
        c++;
      end
      p = s;
    end
  endtask
  task automatic word;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      #1;
      n++;
      if (n > 400) tmo;
    end while (rx_word.valid !== 1'b1);
    got = rx_word;
  endtask
  task automatic t_regs;
    chk(sclk_oe, 1);
    chk(frame_sync_out, 0);
    chk(hresp, 0);
    repeat (20) begin
      @(negedge hclk);
      chk(sclk_out, 0);
    end
    bus(0, csip_pkg::IDX_CHAN_STATE, 0);
    chk(rd, 1);
    bus(0, 6'h3f, 0);
    chk(rd, 0);
    bus(1, csip_pkg::IDX_DIV, 32'hffff_ffff);
    bus(0, csip_pkg::IDX_DIV, 0);
    chk(rd, 32'h1f);
    $display("regs test done");
  endtask
  task automatic t_master;
    bus(1, csip_pkg::IDX_DIV, 1);
    bus(1, csip_pkg::IDX_INTERP_NUM, 80);
    bus(1, csip_pkg::IDX_CHAN_STATE, 4);
    per(0, 4);
    bus(1, csip_pkg::IDX_CHAN_STATE, 0);
    per(0, 2);
    per(1, 80);
    u_csip_host.send_master(32'h8001_7ffe, 32);
    word;
    chk(got.data, 32'h8001_7ffe);
    chk(frame_end_out, 1);
    chk(got.i, 16'h8001);
    chk(got.q, 16'h7ffe);
    chk(got.len, 32);
    $display("master test done");
  endtask
  // every format code once, plus the wide compact word, all slave clocked
  task automatic t_slave;
    bus(1, csip_pkg::IDX_CTRL, 32'h90);
    // the pin direction register follows the control bit one edge later
    repeat (2) @(negedge hclk);
    chk(sclk_oe, 0);
    for (int m = 0; m < 9; m++) begin
      bus(1, csip_pkg::IDX_MODE, m < 8 ? 32'(m) << 4 : 32'h240);
      u_csip_host.send_slave(32'hc3a5_96f0, lens[m]);
      word;
      chk(got.len, lens[m]);
      chk(got.data, 32'hc3a5_96f0 & ~(32'hffff_ffff << lens[m]));
    end
    $display("slave test done");
  endtask
  initial begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs;
    t_master;
    t_slave;
    end_sim;
  end
endmodule // csip_port_tb
